// ---- nic_pkg.sv ----
// Package with register map, encodings and vector layout for the nested interrupt controller
package nic_pkg;
  localparam int unsigned NUM_VEC   = 14;
  localparam int unsigned NUM_EXT   = 4;
  localparam int unsigned EXT_PINS  = 4;
  localparam int unsigned EXT_BASE  = 2;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned NUM_ISP   = 4;
  // Register indices on the plain register port
  localparam logic [2:0] REG_CC   = 3'h0;
  localparam logic [2:0] REG_ISP0 = 3'h1;
  // Condition code register fields
  localparam int unsigned CC_PRI_HI = 5;
  localparam int unsigned CC_PRI_LO = 3;
  localparam logic [7:0] CC_RESET  = 8'hEA;
  localparam logic [7:0] ISP_RESET = 8'hFF;
  localparam logic [7:0] ISP3_RO   = 8'hF0;
  // Priority codes {high bit, low bit}
  localparam logic [1:0] PRI_L0 = 2'h2;
  localparam logic [1:0] PRI_L1 = 2'h1;
  localparam logic [1:0] PRI_L2 = 2'h0;
  localparam logic [1:0] PRI_L3 = 2'h3;
  // Vector addresses
  localparam logic [15:0] VEC_TOP    = 16'hFFFE;
  localparam logic [15:0] VEC_RESET  = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP   = 16'hFFFC;
  localparam logic [15:0] VEC_BASE   = 16'hFFFA;
  localparam logic [15:0] VEC_BOTTOM = 16'hFFE0;
  // Vectors able to leave halt: MCC, ei0..ei3, SPI
  localparam logic [NUM_VEC-1:0] HALT_WAKE = 14'h00BE;
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_RIM   = 3'b001,
    OP_SIM   = 3'b010,
    OP_HALT  = 3'b011,
    OP_WFI   = 3'b100,
    OP_INTERRUPT_RETURN_INSTRUCTION  = 3'b101,
    OP_POPCC = 3'b110
  } cpu_op_t;
endpackage

// ---- nested_interrupt_controller.sv ----
// Nested interrupt controller: pending latches, arbitration, priority bits and wake-up
//
// Behaviour
// RULE_01 - Sixteen vectors, four levels, reset and trap
// RULE_02 - Vectors sit at FFE0h to FFFFh
// RULE_03 - Priority bits at condition code 5, 3
// RULE_04 - Level codes 10, 01, 00, 11
// RULE_05 - Entry after instruction loads priority and vector
// RULE_06 - Return restores both priority bits
// RULE_07 - Highest software level, then hardware order
// RULE_08 - Unserviced requests stay latched as pending
// RULE_09 - Maskable taken only when enabled and higher
// RULE_10 - Reset, trap ignore mask, set level 3
// RULE_11 - Reset and trap preempt level 3 code
// RULE_12 - Trap instruction raises non-maskable trap request
// RULE_13 - After reset run at level 3
// RULE_14 - Non-maskable sources leave halt
// RULE_15 - Edge external request cleared on entry
// RULE_16 - Selected pins of a group are ORed
// RULE_17 - Peripheral request needs flag and enable
// RULE_18 - Clear sequence discards pending peripheral request
// RULE_19 - Any wakes wait; halt-capable ones wake halt
// RULE_20 - After halt first service is halt-capable
// RULE_21 - Instructions may rewrite the priority bits
// RULE_22 - No stack overflow detection
// RULE_23 - Level 0 code in priority field ignored
`timescale 1ns/1ps
module nested_interrupt_controller #(
  parameter int unsigned NUM_VEC  = nic_pkg::NUM_VEC,
  parameter int unsigned EXT_PINS = nic_pkg::EXT_PINS
) (
  input  wire logic                            i_core_clk,     // CPU clock
  input  wire logic                            i_rst,          // Async reset, high
  input  wire logic [nic_pkg::ADDR_W-1:0]      i_reg_addr,     // Register index
  input  wire logic [7:0]                      i_reg_wdata,    // Write data
  input  wire logic                            i_reg_wr,       // Write strobe
  input  wire logic                            i_reg_rd,       // Read strobe
  output logic      [7:0]                      o_reg_rdata,    // Read data, next cycle
  input  wire logic [2:0]                      i_cpu_op,       // Instruction affecting CC
  input  wire logic [7:0]                      i_cpu_cc_data,  // CC popped by INTERRUPT_RETURN_INSTRUCTION/POP CC
  input  wire logic                            i_instr_done,   // Instruction boundary
  input  wire logic                            i_trap_instr,   // Trap instruction executed
  input  wire logic                            i_halt_mode,    // Core is halted
  input  wire logic                            i_wait_mode,    // Core is waiting
  input  wire logic [NUM_VEC-1:0]              i_periph_flag,  // Peripheral status flags
  input  wire logic [NUM_VEC-1:0]              i_periph_en,    // Peripheral enables
  input  wire logic [NUM_VEC-1:0]              i_periph_clear, // Clear sequence done
  input  wire logic [nic_pkg::NUM_EXT*EXT_PINS-1:0] i_ext_pins, // External pins
  input  wire logic [nic_pkg::NUM_EXT*EXT_PINS-1:0] i_ext_sel,  // Pin selects per group
  output logic                                 o_take,         // Interrupt entry pulse
  output logic      [15:0]                     o_vector,       // Vector address to fetch
  output logic                                 o_stack_regs,   // Push PC, X, A, CC
  output logic      [7:0]                      o_cc,           // Condition code register
  output logic                                 o_wake_wait,    // Leave wait
  output logic                                 o_wake_halt     // Leave halt
);
  localparam int unsigned NE = nic_pkg::NUM_EXT;
  localparam int unsigned NP = NE * EXT_PINS;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] pri_rank(input logic [1:0] code);
    unique case (code)
      nic_pkg::PRI_L0: pri_rank = 2'h0;
      nic_pkg::PRI_L1: pri_rank = 2'h1;
      nic_pkg::PRI_L2: pri_rank = 2'h2;
      nic_pkg::PRI_L3: pri_rank = 2'h3;
    endcase
  endfunction // [RULE_04]

  function automatic logic [15:0] vec_addr(input logic [3:0] idx);
    vec_addr = nic_pkg::VEC_BASE - {11'h000, idx, 1'b0};
  endfunction // [RULE_02]

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]           cc_ff;
  logic [7:0]           isp_ff [nic_pkg::NUM_ISP];
  logic [NUM_VEC-1:0]   pend_ff;
  logic                 trap_ff;
  logic                 halt_exit_ff;
  logic [7:0]           rdata_ff;
  logic [NP-1:0]        s1_ff, s2_ff, s3_ff, pin_ff;
  logic [NE-1:0]        line_ff;

  logic [1:0]           cur_rank;
  logic [1:0]           vec_code [NUM_VEC];
  logic [NUM_VEC-1:0]   cand;
  logic [NUM_VEC-1:0]   avail;
  logic                 any_cand;
  logic [3:0]           best_idx;
  logic [1:0]           best_rank;
  logic                 take_mask;
  logic                 take_trap;
  logic [NE-1:0]        line_now;
  logic [NUM_VEC-1:0]   ext_edge;
  logic [NUM_VEC-1:0]   per_req;
  logic [NUM_VEC-1:0]   is_ext;

  assign cur_rank = pri_rank({cc_ff[nic_pkg::CC_PRI_HI], cc_ff[nic_pkg::CC_PRI_LO]});

  genvar gv;
  generate
    for (gv = 0; gv < NUM_VEC; gv++) begin : g_vec
      if (gv / 4 < nic_pkg::NUM_ISP) begin : g_code
        assign vec_code[gv] = isp_ff[gv/4][(gv%4)*2 +: 2];
      end else begin : g_none
        assign vec_code[gv] = nic_pkg::PRI_L0;
      end
      assign is_ext[gv] = (gv >= nic_pkg::EXT_BASE) && (gv < nic_pkg::EXT_BASE + NE);
      // Maskable source must outrank the running level
      assign cand[gv] = pend_ff[gv] && (pri_rank(vec_code[gv]) > cur_rank); // [RULE_09]
      assign per_req[gv] = i_periph_flag[gv] && i_periph_en[gv] && !is_ext[gv]; // [RULE_17]
    end
  endgenerate

  // Right after halt only halt-capable sources may win the first slot
  assign avail = halt_exit_ff ? (cand & nic_pkg::HALT_WAKE) : cand; // [RULE_20]

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  always_comb begin
    any_cand  = 1'b0;
    best_idx  = 4'h0;
    best_rank = 2'h0;
    // Lower index is higher hardware priority, so ties keep the first
    for (int i = 0; i < NUM_VEC; i++) begin
      if (avail[i] && (!any_cand || pri_rank(vec_code[i]) > best_rank)) begin
        any_cand  = 1'b1;
        best_idx  = 4'(i);
        best_rank = pri_rank(vec_code[i]);
      end
    end
  end // [RULE_07]

  // Trap outranks every maskable source, even at level 3
  assign take_trap = i_instr_done && trap_ff; // [RULE_11]
  assign take_mask = i_instr_done && !trap_ff && any_cand; // [RULE_05]

  // ----------------------------------------------------------------
  // External lines: three-stage sync, group OR, edge latch
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      pin_ff <= '0;
    end else begin
      s1_ff <= i_ext_pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int p = 0; p < NP; p++) begin
        if (s2_ff[p] == s3_ff[p]) begin
          pin_ff[p] <= s3_ff[p];
        end
      end
    end
  end

  always_comb begin
    for (int e = 0; e < NE; e++) begin
      line_now[e] = |(pin_ff[e*EXT_PINS +: EXT_PINS] & i_ext_sel[e*EXT_PINS +: EXT_PINS]);
    end // [RULE_16]
    ext_edge = '0;
    for (int e = 0; e < NE; e++) begin
      ext_edge[nic_pkg::EXT_BASE + e] = line_now[e] && !line_ff[e];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      line_ff <= '0;
    end else begin
      line_ff <= line_now;
    end
  end

  // ----------------------------------------------------------------
  // Pending latches
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_ff <= '0;
    end else begin
      for (int v = 0; v < NUM_VEC; v++) begin
        if (ext_edge[v] || per_req[v]) begin
          pend_ff[v] <= 1'b1; // [RULE_08]
        end else if (is_ext[v] && take_mask && best_idx == 4'(v)) begin
          pend_ff[v] <= 1'b0; // [RULE_15]
        end else if (!is_ext[v] && i_periph_clear[v]) begin
          pend_ff[v] <= 1'b0; // [RULE_18]
        end
      end
    end
  end

  // A trap raised in the entry cycle of another trap is kept
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      trap_ff <= 1'b0;
    end else if (i_trap_instr) begin
      trap_ff <= 1'b1; // [RULE_12]
    end else if (take_trap) begin
      trap_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      halt_exit_ff <= 1'b0;
    end else if (i_halt_mode && o_wake_halt) begin
      halt_exit_ff <= 1'b1;
    end else if (take_mask || take_trap) begin
      halt_exit_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Condition code register
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cc_ff <= nic_pkg::CC_RESET; // [RULE_13]
    end else if (take_trap) begin
      cc_ff[nic_pkg::CC_PRI_HI] <= nic_pkg::PRI_L3[1]; // [RULE_10]
      cc_ff[nic_pkg::CC_PRI_LO] <= nic_pkg::PRI_L3[0];
    end else if (take_mask) begin
      cc_ff[nic_pkg::CC_PRI_HI] <= vec_code[best_idx][1]; // [RULE_05] [RULE_03]
      cc_ff[nic_pkg::CC_PRI_LO] <= vec_code[best_idx][0];
    end else begin
      unique case (i_cpu_op)
        nic_pkg::OP_RIM, nic_pkg::OP_HALT, nic_pkg::OP_WFI: begin
          cc_ff[nic_pkg::CC_PRI_HI] <= nic_pkg::PRI_L0[1]; // [RULE_21]
          cc_ff[nic_pkg::CC_PRI_LO] <= nic_pkg::PRI_L0[0];
        end
        nic_pkg::OP_SIM: begin
          cc_ff[nic_pkg::CC_PRI_HI] <= nic_pkg::PRI_L3[1];
          cc_ff[nic_pkg::CC_PRI_LO] <= nic_pkg::PRI_L3[0];
        end
        nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, nic_pkg::OP_POPCC: begin
          cc_ff <= i_cpu_cc_data; // [RULE_06]
        end
        default: begin
          if (i_reg_wr && i_reg_addr == nic_pkg::REG_CC) begin
            cc_ff <= i_reg_wdata;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software priority registers
  // ----------------------------------------------------------------
  generate
    for (gv = 0; gv < nic_pkg::NUM_ISP; gv++) begin : g_isp
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          isp_ff[gv] <= nic_pkg::ISP_RESET;
        end else if (i_reg_wr && i_reg_addr == nic_pkg::REG_ISP0 + 3'(gv)) begin
          for (int f = 0; f < 4; f++) begin
            if (i_reg_wdata[f*2 +: 2] != nic_pkg::PRI_L0) begin
              isp_ff[gv][f*2 +: 2] <= i_reg_wdata[f*2 +: 2]; // [RULE_23]
            end
          end
          if (gv == nic_pkg::NUM_ISP - 1) begin
            isp_ff[gv][7:4] <= nic_pkg::ISP3_RO[7:4];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read port and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= '0;
    end else if (i_reg_rd) begin
      if (i_reg_addr == nic_pkg::REG_CC) begin
        rdata_ff <= cc_ff;
      end else if (i_reg_addr >= nic_pkg::REG_ISP0 &&
                   i_reg_addr < nic_pkg::REG_ISP0 + 3'(nic_pkg::NUM_ISP)) begin
        rdata_ff <= isp_ff[2'(i_reg_addr - nic_pkg::REG_ISP0)];
      end else begin
        rdata_ff <= '0;
      end
    end else begin
      rdata_ff <= '0;
    end
  end

  // Vector output starts at the reset vector, no stacking on reset
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_take       <= 1'b0;
      o_vector     <= nic_pkg::VEC_RESET; // [RULE_13]
      o_stack_regs <= 1'b0;
    end else begin
      o_take <= take_trap || take_mask;
      if (take_trap) begin
        o_vector     <= nic_pkg::VEC_TRAP; // [RULE_10]
        o_stack_regs <= 1'b1;
      end else if (take_mask) begin
        o_vector     <= vec_addr(best_idx); // [RULE_01]
        o_stack_regs <= 1'b1;
      end
    end
  end

  // Nesting depth is bounded only by stack RAM; nothing here watches it [RULE_22]
  assign o_reg_rdata = rdata_ff;
  assign o_cc        = cc_ff;
  assign o_wake_wait = i_wait_mode && ((|pend_ff) || trap_ff); // [RULE_19]
  assign o_wake_halt = i_halt_mode && ((|(pend_ff & nic_pkg::HALT_WAKE)) || trap_ff); // [RULE_14]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [1:0] cc_rank_q;
  assign cc_rank_q = pri_rank({o_cc[nic_pkg::CC_PRI_HI], o_cc[nic_pkg::CC_PRI_LO]});

  sequence s_trap_entry;
    i_instr_done && trap_ff;
  endsequence

  property p_trap_level3;
    @(posedge i_core_clk) disable iff (i_rst)
      s_trap_entry |=> (o_take && o_vector == nic_pkg::VEC_TRAP && cc_rank_q == 2'h3);
  endproperty
  a_trap_level3: assert property (p_trap_level3) else $error("trap entry wrong"); // [RULE_10]

  property p_trap_over_mask;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_instr_done && trap_ff && (|pend_ff)) |=> o_vector == nic_pkg::VEC_TRAP;
  endproperty
  a_trap_over_mask: assert property (p_trap_over_mask) else $error("trap lost"); // [RULE_11]

  property p_mask_higher;
    @(posedge i_core_clk) disable iff (i_rst)
      take_mask |=> cc_rank_q > $past(cur_rank);
  endproperty
  a_mask_higher: assert property (p_mask_higher) else $error("masked taken"); // [RULE_09]

  property p_level_load;
    @(posedge i_core_clk) disable iff (i_rst)
      take_mask |=> ({o_cc[nic_pkg::CC_PRI_HI], o_cc[nic_pkg::CC_PRI_LO]}
                     == $past(vec_code[best_idx])) && o_stack_regs;
  endproperty
  a_level_load: assert property (p_level_load) else $error("level not loaded"); // [RULE_05]

  property p_vec_range;
    @(posedge i_core_clk) disable iff (i_rst)
      o_take |-> (o_vector >= nic_pkg::VEC_BOTTOM && o_vector <= nic_pkg::VEC_TOP);
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range"); // [RULE_02]

  property p_pend_hold;
    @(posedge i_core_clk) disable iff (i_rst)
      (pend_ff[1] && !take_mask && !i_periph_clear[1]) |=> pend_ff[1];
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped"); // [RULE_08]

  property p_no_level0;
    @(posedge i_core_clk) disable iff (i_rst)
      ##1 (vec_code[0] != nic_pkg::PRI_L0);
  endproperty
  a_no_level0: assert property (p_no_level0) else $error("level 0 stored"); // [RULE_23]

  property p_interrupt_return_instruction_restore;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_cpu_op == nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION && !take_mask && !take_trap) |=>
        o_cc == $past(i_cpu_cc_data);
  endproperty
  a_interrupt_return_instruction_restore: assert property (p_interrupt_return_instruction_restore) else $error("interrupt_return_instruction not restored"); // [RULE_06]

  property p_halt_first;
    @(posedge i_core_clk) disable iff (i_rst)
      (take_mask && halt_exit_ff) |-> nic_pkg::HALT_WAKE[best_idx];
  endproperty
  a_halt_first: assert property (p_halt_first) else $error("halt first wrong"); // [RULE_20]

  property p_ext_clear;
    @(posedge i_core_clk) disable iff (i_rst)
      (take_mask && best_idx == 4'(nic_pkg::EXT_BASE) && !ext_edge[nic_pkg::EXT_BASE])
        |=> !pend_ff[nic_pkg::EXT_BASE];
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("edge not cleared"); // [RULE_15]
endmodule

// ---- core_model.sv ----
// Model of the CPU core and the interrupting peripherals around the controller
`timescale 1ns/1ps
module core_model (
  input  wire logic        i_core_clk,   // CPU clock
  input  wire logic        i_rst,        // Async reset, high
  input  wire logic        i_slow,       // Boundary only every third cycle
  input  wire logic        i_stopped,    // Core halted or waiting
  input  wire logic        i_take,       // Entry pulse from controller
  input  wire logic [15:0] i_vector,     // Vector being entered
  input  wire logic [13:0] i_raise,      // Set peripheral flags
  input  wire logic [13:0] i_drop,       // Software clear sequence request
  output logic             o_instr_done, // Instruction boundary
  output logic      [13:0] o_flag,       // Peripheral status flags
  output logic      [13:0] o_clear       // Clear sequence done
);
  logic [1:0]  cnt_ff;
  logic [13:0] req;
  logic [4:0]  idx;

  // --------------------------------------------------------------
  // Service routine of a peripheral vector clears its own flag
  // --------------------------------------------------------------
  always_comb begin
    idx = 5'((nic_pkg::VEC_BASE - i_vector) >> 1);
    req = i_drop;
    if (i_take && i_vector <= nic_pkg::VEC_BASE && (idx < 5'd2 || idx > 5'd5)) begin
      req[idx] = 1'b1;
    end
  end

  // Instructions finish only while the core runs
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff       <= 2'h0;
      o_instr_done <= 1'b0;
    end else begin
      cnt_ff       <= (cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
      o_instr_done <= !i_stopped && (!i_slow || cnt_ff == 2'h0);
    end
  end

  // Flag drop and clear land together, so the clear is not beaten by a set and the
  // latch is gone before a return one cycle after entry can reopen the level
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flag  <= 14'h0000;
      o_clear <= 14'h0000;
    end else begin
      o_flag  <= (o_flag | i_raise) & ~req;
      o_clear <= req;
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking testbench for the nested interrupt controller
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        rst;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [2:0]  cpu_op;
  logic [7:0]  cc_data;
  logic        instr_done;
  logic        trap;
  logic        halt_mode;
  logic        wait_mode;
  logic        slow;
  logic [13:0] flag;
  logic [13:0] en;
  logic [13:0] clr;
  logic [13:0] raise;
  logic [13:0] drop;
  logic [15:0] pins;
  logic [15:0] sel;
  logic        take;
  logic [15:0] vec;
  logic        stack;
  logic [7:0]  cc;
  logic        wake_wait;
  logic        wake_halt;
  logic [2:0]  ops [6];
  logic [7:0]  odat [6];
  logic [7:0]  occ [6];
  int          bad_count;
  int          checks_done;

  nested_interrupt_controller dut (
    .i_core_clk(clk), .i_rst(rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .i_cpu_op(cpu_op),
    .i_cpu_cc_data(cc_data), .i_instr_done(instr_done), .i_trap_instr(trap),
    .i_halt_mode(halt_mode), .i_wait_mode(wait_mode), .i_periph_flag(flag),
    .i_periph_en(en), .i_periph_clear(clr), .i_ext_pins(pins), .i_ext_sel(sel),
    .o_take(take), .o_vector(vec), .o_stack_regs(stack), .o_cc(cc),
    .o_wake_wait(wake_wait), .o_wake_halt(wake_halt));

  core_model partner (
    .i_core_clk(clk), .i_rst(rst), .i_slow(slow), .i_stopped(halt_mode | wait_mode),
    .i_take(take), .i_vector(vec), .i_raise(raise), .i_drop(drop),
    .o_instr_done(instr_done), .o_flag(flag), .o_clear(clr));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask

  task automatic op(input logic [2:0] code, input logic [7:0] d);
    @(posedge clk);
    cpu_op  <= code;
    cc_data <= d;
    @(posedge clk);
    cpu_op  <= 3'h0;
  endtask

  // which: 0 raise flags, 1 clear sequence, 2 trap instruction
  task automatic pulse(input int which, input logic [13:0] m);
    @(posedge clk);
    if (which == 0) raise <= m;
    else if (which == 1) drop <= m;
    else trap <= 1'b1;
    @(posedge clk);
    raise <= 14'h0000;
    drop  <= 14'h0000;
    trap  <= 1'b0;
  endtask

  task automatic wait_take(input logic [15:0] v, input logic [1:0] p);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (take !== 1'b1 && n < 40);
    check("take", 16'h0001, {15'h0000, take});
    check("vector", v, vec);
    check("level", {14'h0000, p}, {14'h0000, cc[5], cc[3]});
    check("stacking", 16'h0001, {15'h0000, stack});
  endtask

  task automatic no_take(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      tick(1);
      if (take !== 1'b0) seen = 1'b1;
    end
    check("no take", 16'h0000, {15'h0000, seen});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is under a thousand cycles
  initial begin
    #100000;
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    end_of_test();
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, cpu_op, cc_data} = '0;
    {trap, halt_mode, wait_mode, slow, raise, drop, pins, sel} = '0;
    en = 14'h3FFF;
    bad_count = 0;
    checks_done = 0;
    ops  = '{nic_pkg::OP_RIM, nic_pkg::OP_SIM, nic_pkg::OP_HALT, nic_pkg::OP_POPCC,
             nic_pkg::OP_WFI, nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION};
    odat = '{8'h00, 8'h00, 8'h00, 8'hEA, 8'h00, 8'hC2};
    occ  = '{8'hE2, 8'hEA, 8'hE2, 8'hEA, 8'hE2, 8'hC2};
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    check("vector rst", nic_pkg::VEC_RESET, vec);
    check("stack rst", 16'h0000, {15'h0000, stack});
    rd(nic_pkg::REG_CC, nic_pkg::CC_RESET, "cc rst");
    for (int r = 0; r < 4; r++) rd(nic_pkg::REG_ISP0 + 3'(r), 8'hFF, "isp rst");
    $display("reset test done");

    wr(nic_pkg::REG_ISP0, 8'hCF);
    wr(nic_pkg::REG_ISP0, 8'h64);
    rd(nic_pkg::REG_ISP0, 8'h44, "isp keep");
    wr(3'h4, 8'h00);
    rd(3'h4, 8'hF0, "isp3 upper");
    wr(3'h7, 8'h55);
    rd(3'h7, 8'h00, "unmapped");
    wr(nic_pkg::REG_CC, 8'hE2);
    rd(nic_pkg::REG_CC, 8'hE2, "cc write");
    for (int k = 0; k < 6; k++) begin
      op(ops[k], odat[k]);
      #1;
      check("cc op", {8'h00, occ[k]}, {8'h00, cc});
    end
    rd(nic_pkg::REG_CC, 8'hC2, "cc read");
    $display("register test done");

    // vec1 level 1, vec7 level 2, vec8 level 2
    wr(3'h1, 8'hF7);
    wr(3'h2, 8'h3F);
    wr(3'h3, 8'hFC);
    slow <= 1'b1;
    op(nic_pkg::OP_RIM, 8'h00);
    pulse(0, 14'h0182);
    wait_take(16'hFFEC, nic_pkg::PRI_L2);
    no_take(10);
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hE2);
    wait_take(16'hFFEA, nic_pkg::PRI_L2);
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hE2);
    wait_take(16'hFFF8, nic_pkg::PRI_L1);
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hE2);
    slow <= 1'b0;
    $display("arbitration test done");

    op(nic_pkg::OP_SIM, 8'h00);
    pulse(0, 14'h0100);
    no_take(8);
    @(posedge clk);
    halt_mode <= 1'b1;
    pulse(2, 14'h0000);
    tick(2);
    check("halt wake trap", 16'h0001, {15'h0000, wake_halt});
    @(posedge clk);
    halt_mode <= 1'b0;
    wait_take(nic_pkg::VEC_TRAP, nic_pkg::PRI_L3);
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hE2);
    wait_take(16'hFFEA, nic_pkg::PRI_L2);
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hE2);
    $display("trap test done");

    op(nic_pkg::OP_WFI, 8'h00);
    @(posedge clk);
    wait_mode <= 1'b1;
    pulse(0, 14'h0100);
    tick(2);
    check("wait wake", 16'h0001, {15'h0000, wake_wait});
    @(posedge clk);
    wait_mode <= 1'b0;
    halt_mode <= 1'b1;
    tick(2);
    check("halt no wake", 16'h0000, {15'h0000, wake_halt});
    pulse(0, 14'h0002);
    tick(2);
    check("halt wake", 16'h0001, {15'h0000, wake_halt});
    @(posedge clk);
    halt_mode <= 1'b0;
    wait_take(16'hFFF8, nic_pkg::PRI_L1);
    wait_take(16'hFFEA, nic_pkg::PRI_L2);
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hCA);
    #1;
    check("cc return", 16'h00CA, {8'h00, cc});
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hE2);
    $display("wake test done");

    // vec2 level 1, group 0 pins 0 and 2 selected
    wr(3'h1, 8'hDF);
    @(posedge clk);
    sel <= 16'h0005;
    @(posedge clk);
    pins <= 16'h0008;
    no_take(10);
    @(posedge clk);
    pins <= 16'h000C;
    wait_take(16'hFFF6, nic_pkg::PRI_L1);
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hE2);
    no_take(10);
    pins <= 16'h0000;
    $display("external test done");

    // vec8 and vec9 level 2, vec9 disabled first
    wr(3'h3, 8'hF0);
    en <= 14'h3DFF;
    pulse(0, 14'h0200);
    no_take(10);
    pulse(1, 14'h0200);
    en <= 14'h3FFF;
    op(nic_pkg::OP_SIM, 8'h00);
    pulse(0, 14'h0200);
    pulse(1, 14'h0200);
    tick(3);
    op(nic_pkg::OP_RIM, 8'h00);
    no_take(10);
    pulse(0, 14'h0200);
    wait_take(16'hFFE8, nic_pkg::PRI_L2);
    op(nic_pkg::OP_INTERRUPT_RETURN_INSTRUCTION, 8'hE2);
    $display("peripheral test done");
    end_of_test();
  end
endmodule
